// File: pvsr_consts.svh
// register offsets, field positions and reset values of the vendor status bank
`ifndef PVSR_CONSTS_SVH
`define PVSR_CONSTS_SVH
`define PVSR_ADDR_TALLY 5'h1a
`define PVSR_ADDR_XOVER 5'h1b
`define PVSR_ADDR_FLAGS 5'h1d
`define PVSR_ADDR_MASK 5'h1e
`define PVSR_ADDR_NEG 5'h1f
`define PVSR_ADDR_MODE 5'h11
`define PVSR_BIT_XOVER_AUTO_DIS 15
`define PVSR_BIT_PAIR_SWAP 13
`define PVSR_BIT_HB_OFF 11
`define PVSR_BIT_POL_REV 4
`define PVSR_BIT_ALT_IRQ 6
`define PVSR_BIT_NEG_DONE 12
`define PVSR_BIT_CODER_EN 6
`define PVSR_SPD_LSB 2
`define PVSR_FLAG_LSB 1
`define PVSR_RST_TALLY 16'h0000
`define PVSR_RST_MASK 7'h00
`define PVSR_RST_CODER_EN 1'b1
`define PVSR_SPD_10_HALF 3'h1
`define PVSR_SPD_10_FULL 3'h5
`define PVSR_SPD_100_HALF 3'h2
`define PVSR_SPD_100_FULL 3'h6
`endif

// File: pvsr_pkg.sv
// types shared by the vendor status bank
package pvsr_pkg;
    // management access from the serial interface front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pvsr_mgmt_req_s;
    // one-cycle event strobes from the transceiver core, msb = energy
    typedef struct packed {
        logic energy_detected;
        logic negotiation_complete;
        logic remote_fault;
        logic link_down;
        logic partner_acknowledge;
        logic parallel_detect_fault;
        logic page_received;
    } pvsr_events_s;
    // symbol receiver state for error tracking
    typedef enum logic [0:0] {
        PVSR_RX_IDLE,
        PVSR_RX_PACKET
    } pvsr_rx_e;
endpackage : pvsr_pkg

// File: pvsr_bank.sv
// vendor status and control register bank of a 10/100 transceiver
`include "pvsr_consts.svh"
// Notes on behaviour
// - in 100 mode each invalid code group outside a packet advances the 16-bit tally
// - tally advances at most once per received packet
// - tally wraps from maximum to zero
// - tally clears on reset; reading never alters it
// - in 10 mode the tally holds still
// - crossover bit clear means automatic; set means manual channel select decides
// - manual select zero gives straight pairs, one gives swapped pairs
// - heartbeat off bit stops the test; soft reset keeps it
// - receive polarity reversal reads in read-only bit 4
// - flags 7,6,5 latch energy, negotiation done, remote fault; reset zero
// - flags 4..1 latch link down, acknowledge, parallel fault, page received
// - mask bits 7:1 writable, one enables, reset to zero
// - bit 12 reads one only once negotiation finished
// - bit 6 enables the 4b5b coder, reset one; host uses it with mii only
// - bits 4:2 report resolved speed and duplex codes
// - alternate scheme bit selects how the source flags behave
module pvsr_bank
    import pvsr_pkg::*;
#(
    parameter int TALLY_W = 16
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic soft_reset_i,
    input pvsr_mgmt_req_s req_i,
    input pvsr_events_s events_i,
    input wire logic speed_100_i,
    input wire logic full_duplex_i,
    input wire logic rx_invalid_group_i,
    input wire logic rx_in_packet_i,
    input wire logic polarity_reversed_i,
    input wire logic negotiation_done_i,
    input wire logic energy_present_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic irq_o,
    output logic crossover_auto_disable_o,
    output logic manual_pair_swap_o,
    output logic heartbeat_test_off_o,
    output logic coder_enable_o,
    output logic alternate_irq_scheme_o
);
    logic [TALLY_W-1:0] symbol_error_tally;
    logic [6:0] flags;
    logic [6:0] mask;
    logic [6:0] evt_vec;
    logic [6:0] flag_clr;
    logic [2:0] next_speed;
    logic [15:0] next_rdata;
    logic any_reset;
    logic wr_xover;
    logic wr_mask;
    logic wr_neg;
    logic wr_mode;
    logic rd_flags;
    logic counted_this_packet;
    logic energy_q;
    pvsr_rx_e rx_state;

    // decode of a management write to one address
    function automatic logic wr_hit(input pvsr_mgmt_req_s r, input logic [4:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    assign any_reset = reset_i || soft_reset_i;
    assign wr_xover = wr_hit(req_i, `PVSR_ADDR_XOVER);
    assign wr_mask = wr_hit(req_i, `PVSR_ADDR_MASK);
    assign wr_neg = wr_hit(req_i, `PVSR_ADDR_NEG);
    assign wr_mode = wr_hit(req_i, `PVSR_ADDR_MODE);
    assign rd_flags = req_i.rd && (req_i.addr == `PVSR_ADDR_FLAGS);
    assign evt_vec = events_i;

    // packet framing for once-per-packet error counting
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            rx_state <= PVSR_RX_IDLE;
        end
        else
        begin
            rx_state <= rx_in_packet_i ? PVSR_RX_PACKET : PVSR_RX_IDLE;
        end
    end

    // symbol error tally, wraps, frozen in 10 mode
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            symbol_error_tally <= TALLY_W'(`PVSR_RST_TALLY);
            counted_this_packet <= 1'b0;
        end
        else
        begin
            if (rx_in_packet_i && rx_state == PVSR_RX_IDLE)
            begin
                counted_this_packet <= 1'b0;
            end
            if (speed_100_i && rx_invalid_group_i)
            begin
                if (!rx_in_packet_i)
                begin
                    symbol_error_tally <= symbol_error_tally + 1'b1;
                end
                else if (!counted_this_packet || rx_state == PVSR_RX_IDLE)
                begin
                    symbol_error_tally <= symbol_error_tally + 1'b1;
                    counted_this_packet <= 1'b1;
                end
            end
        end
    end

    // crossover control; heartbeat bit survives soft reset
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            crossover_auto_disable_o <= 1'b0;
            manual_pair_swap_o <= 1'b0;
        end
        else if (wr_xover)
        begin
            crossover_auto_disable_o <= req_i.wdata[`PVSR_BIT_XOVER_AUTO_DIS];
            manual_pair_swap_o <= req_i.wdata[`PVSR_BIT_PAIR_SWAP];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            heartbeat_test_off_o <= 1'b0;
        end
        else if (wr_xover)
        begin
            heartbeat_test_off_o <= req_i.wdata[`PVSR_BIT_HB_OFF];
        end
    end

    // mask, coder enable and irq scheme configuration
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            mask <= `PVSR_RST_MASK;
            coder_enable_o <= `PVSR_RST_CODER_EN;
            alternate_irq_scheme_o <= 1'b0;
        end
        else
        begin
            if (wr_mask)
            begin
                mask <= req_i.wdata[7:`PVSR_FLAG_LSB];
            end
            if (wr_neg)
            begin
                coder_enable_o <= req_i.wdata[`PVSR_BIT_CODER_EN];
            end
            if (wr_mode)
            begin
                alternate_irq_scheme_o <= req_i.wdata[`PVSR_BIT_ALT_IRQ];
            end
        end
    end

    // flag clearing: primary clears on read, alternate clears on a read once source is gone
    always_comb
    begin
        flag_clr = 7'h00;
        if (!alternate_irq_scheme_o)
        begin
            flag_clr = rd_flags ? 7'h7f : 7'h00;
        end
        else
        begin
            flag_clr = rd_flags ? ~evt_vec : 7'h00;
            flag_clr[6] = rd_flags && !energy_present_i;
        end
    end

    // energy flag fires on rising energy presence too
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            energy_q <= 1'b0;
        end
        else
        begin
            energy_q <= energy_present_i;
        end
    end

    // latched source flags, set wins over clear
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            flags <= 7'h00;
        end
        else
        begin
            flags <= (flags & ~flag_clr) | evt_vec
                | {energy_present_i && !energy_q, 6'h00};
        end
    end

    // interrupt request when a flag meets its mask
    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(((flags & ~flag_clr) | evt_vec) & mask);
        end
    end

    // resolved speed and duplex code
    always_comb
    begin
        unique case ({speed_100_i, full_duplex_i})
            2'b00: next_speed = `PVSR_SPD_10_HALF;
            2'b01: next_speed = `PVSR_SPD_10_FULL;
            2'b10: next_speed = `PVSR_SPD_100_HALF;
            2'b11: next_speed = `PVSR_SPD_100_FULL;
        endcase
    end

    // read mux, reserved bits zero
    always_comb
    begin
        next_rdata = 16'h0000;
        unique case (req_i.addr)
            `PVSR_ADDR_TALLY: next_rdata = 16'(symbol_error_tally);
            `PVSR_ADDR_XOVER:
            begin
                next_rdata[`PVSR_BIT_XOVER_AUTO_DIS] = crossover_auto_disable_o;
                next_rdata[`PVSR_BIT_PAIR_SWAP] = manual_pair_swap_o;
                next_rdata[`PVSR_BIT_HB_OFF] = heartbeat_test_off_o;
                next_rdata[`PVSR_BIT_POL_REV] = polarity_reversed_i;
            end
            `PVSR_ADDR_FLAGS: next_rdata[7:`PVSR_FLAG_LSB] = flags;
            `PVSR_ADDR_MASK: next_rdata[7:`PVSR_FLAG_LSB] = mask;
            `PVSR_ADDR_NEG:
            begin
                next_rdata[`PVSR_BIT_NEG_DONE] = negotiation_done_i;
                next_rdata[`PVSR_BIT_CODER_EN] = coder_enable_o;
                next_rdata[4:`PVSR_SPD_LSB] = next_speed;
            end
            `PVSR_ADDR_MODE:
            begin
                next_rdata[`PVSR_BIT_ALT_IRQ] = alternate_irq_scheme_o;
                next_rdata[1] = energy_present_i;
            end
            default: next_rdata = 16'h0000;
        endcase
    end

    // registered read answer
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= req_i.rd;
            if (req_i.rd)
            begin
                rdata_o <= next_rdata;
            end
        end
    end
endmodule : pvsr_bank

// File: pvsr_bank_asserts.sv
// concurrent checks of the vendor status register bank
module pvsr_bank_asserts import pvsr_pkg::*; (
    input logic clk_i,
    input logic reset_i,
    input logic soft_reset_i,
    input pvsr_mgmt_req_s req_i,
    input pvsr_events_s events_i,
    input logic speed_100_i,
    input logic full_duplex_i,
    input logic polarity_reversed_i,
    input logic negotiation_done_i,
    input logic energy_present_i,
    input logic [15:0] rdata_o,
    input logic irq_o,
    input logic crossover_auto_disable_o,
    input logic heartbeat_test_off_o,
    input logic coder_enable_o,
    input logic alternate_irq_scheme_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // read request to one offset
    function automatic logic rd_at(input logic [4:0] a);
        return req_i.rd && req_i.addr == a;
    endfunction : rd_at
    // two tally reads two cycles apart in 10 mode, nothing that may move it
    sequence s_tally_twice;
        !soft_reset_i && !speed_100_i ##1 !soft_reset_i && !speed_100_i && rd_at(5'h1a)
        ##1 !soft_reset_i && !speed_100_i
        ##1 !soft_reset_i && !speed_100_i && rd_at(5'h1a);
    endsequence
    // event pulse, then a flag read three cycles later with no clear between
    sequence s_event_read;
        events_i != 7'h0 && !soft_reset_i ##1 !soft_reset_i && !req_i.rd
        ##1 !soft_reset_i && !req_i.rd ##1 !soft_reset_i && rd_at(5'h1d);
    endsequence
    // primary clearing read, quiet sources, then a second flag read
    sequence s_clear_read;
        rd_at(5'h1d) && !alternate_irq_scheme_o && events_i == 7'h0 && !energy_present_i
        ##1 events_i == 7'h0 && !energy_present_i ##1 rd_at(5'h1d);
    endsequence
    property p_tally_held;
        s_tally_twice |=> rdata_o == $past(rdata_o);
    endproperty
    property p_flags_latch;
        s_event_read |=> (rdata_o[7:1] & $past(events_i, 4)) == $past(events_i, 4);
    endproperty
    property p_read_clears;
        s_clear_read |=> rdata_o[7:1] == 7'h0;
    endproperty
    property p_mask_off;
        req_i.wr && req_i.addr == 5'h1e && req_i.wdata[7:1] == 7'h0 |-> ##2 !irq_o;
    endproperty
    property p_reset_vals;
        $fell(reset_i) |-> !irq_o && coder_enable_o && !crossover_auto_disable_o;
    endproperty
    property p_xover_read;
        rd_at(5'h1b) |=> rdata_o[4] == $past(polarity_reversed_i)
            && rdata_o[15] == $past(crossover_auto_disable_o);
    endproperty
    property p_neg_read;
        rd_at(5'h1f) |=> rdata_o[12] == $past(negotiation_done_i) && rdata_o[6] == $past(
            coder_enable_o) && rdata_o[4:2] == {$past(full_duplex_i), $past(speed_100_i),
            !$past(speed_100_i)};
    endproperty
    property p_reserved;
        rd_at(5'h1d) || rd_at(5'h1e) |=> rdata_o[15:8] == 8'h0 && !rdata_o[0];
    endproperty
    property p_soft_keep;
        soft_reset_i && !req_i.wr |=> heartbeat_test_off_o == $past(heartbeat_test_off_o)
            && !crossover_auto_disable_o;
    endproperty
    a_tally_held: assert property (p_tally_held) else $error("tally moved");
    a_flags_latch: assert property (p_flags_latch) else $error("flag lost");
    a_read_clears: assert property (p_read_clears) else $error("flag kept");
    a_mask_off: assert property (p_mask_off) else $error("masked irq");
    a_reset_vals: assert property (p_reset_vals) else $error("reset value");
    a_xover_read: assert property (p_xover_read) else $error("xover read");
    a_neg_read: assert property (p_neg_read) else $error("status read");
    a_reserved: assert property (p_reserved) else $error("reserved bit");
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset");
endmodule : pvsr_bank_asserts

// File: pvsr_host.sv
// management host model issuing single reads and writes
module pvsr_host import pvsr_pkg::*; (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output pvsr_mgmt_req_s req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus from time zero; coder left on, mac side taken as mii
    initial req_o = '0;
    // one-cycle write pulse
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge clk_i) req_o <= '{1'b0, 1'b1, a, v};
        @(negedge clk_i) req_o <= '0;
    endtask : wr
    // one-cycle read pulse, data taken while valid stands
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(negedge clk_i) req_o <= '{1'b1, 1'b0, a, 16'h0};
        @(negedge clk_i) req_o <= '0;
        v = rvalid_i ? rdata_i : 16'hxxxx;
    endtask : rd
endmodule : pvsr_host

// File: test_pvsr_bank.sv
// self-checking bench of the vendor status register bank
module test_pvsr_bank import pvsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TW = 4;
    logic clk_i = 0, reset_i = 1, soft_reset_i = 0, speed_100_i = 0, full_duplex_i = 0;
    logic rx_invalid_group_i = 0, rx_in_packet_i = 0, polarity_reversed_i = 1;
    logic negotiation_done_i = 0, energy_present_i = 0, rvalid_o, irq_o, manual_pair_swap_o;
    logic crossover_auto_disable_o, heartbeat_test_off_o, coder_enable_o, alternate_irq_scheme_o;
    logic [15:0] rdata_o, d;
    logic [31:0] seed = 98, r;
    pvsr_mgmt_req_s req_i;
    pvsr_events_s events_i = '0;
    int error_cnt = 0, cmp_count = 0;
    initial forever #10 clk_i = ~clk_i;
    pvsr_bank #(.TALLY_W(TW)) pvsr_bank_i (.*);
    pvsr_host pvsr_host_i (.clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected negotiation status word
    function automatic logic [15:0] neg_exp(input logic s, input logic f, input logic n);
        return {3'h0, n, 5'h0, 1'b1, 1'b0, f, s, ~s, 2'h0};
    endfunction : neg_exp
    task automatic cmp(input logic [15:0] e, input logic [15:0] s, input string n);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input string n);
        pvsr_host_i.rd(a, d);
        cmp(e, d, n);
    endtask : rd
    // invalid code group pulses
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(negedge clk_i) rx_invalid_group_i <= 1;
            @(negedge clk_i) rx_invalid_group_i <= 0;
        end
    endtask : pulse
    task automatic stop_test();
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // hang guard
    initial
    begin
        #100us;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) reset_i <= 0;
        cmp(16'h4, 16'({coder_enable_o, crossover_auto_disable_o, irq_o}), "outs");
        rd(5'h1a, 16'h0, "tally");
        rd(5'h1e, 16'h0, "mask");
        rd(5'h1d, 16'h0, "flags");
        pvsr_host_i.wr(5'h1b, 16'hffff);
        cmp(16'h3, 16'({crossover_auto_disable_o, manual_pair_swap_o}), "pair");
        rd(5'h1b, 16'ha810, "xover");
        @(negedge clk_i) soft_reset_i <= 1;
        @(negedge clk_i) soft_reset_i <= 0;
        rd(5'h1b, 16'h0810, "soft");
        pvsr_host_i.wr(5'h11, 16'h0040);
        cmp(16'h1, 16'(alternate_irq_scheme_o), "alt");
        // alternate scheme: energy flag survives reads while energy stands
        @(negedge clk_i) energy_present_i <= 1;
        rd(5'h1d, 16'h0080, "alt_energy");
        rd(5'h1d, 16'h0080, "alt_keep");
        @(negedge clk_i) energy_present_i <= 0;
        rd(5'h1d, 16'h0080, "alt_last");
        rd(5'h1d, 16'h0000, "alt_clear");
        pvsr_host_i.wr(5'h11, 16'h0);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk_i) {negotiation_done_i, full_duplex_i, speed_100_i} <= i[2:0];
            rd(5'h1f, neg_exp(i[0], i[1], i[2]), "neg");
        end
        pulse(3);
        rd(5'h1a, 16'h3, "idle");
        @(negedge clk_i) rx_in_packet_i <= 1;
        pulse(5);
        @(negedge clk_i) rx_in_packet_i <= 0;
        rd(5'h1a, 16'h4, "pkt");
        @(negedge clk_i) speed_100_i <= 0;
        pulse(2);
        rd(5'h1a, 16'h4, "ten");
        rd(5'h1a, 16'h4, "ten_again");
        @(negedge clk_i) speed_100_i <= 1;
        pulse(12);
        rd(5'h1a, 16'((4 + 12) % (1 << TW)), "wrap");
        // random masks and events
        repeat (24)
        begin
            r = rnd();
            pvsr_host_i.wr(5'h1e, r[31:16]);
            rd(5'h1e, {8'h0, r[23:17], 1'b0}, "mask");
            @(negedge clk_i) events_i <= r[6:0];
            @(negedge clk_i) events_i <= '0;
            @(negedge clk_i);
            cmp(16'(|(r[6:0] & r[23:17])), 16'(irq_o), "irq");
            rd(5'h1d, {8'h0, r[6:0], 1'b0}, "flags");
            rd(5'h1d, 16'h0, "clear");
        end
        // corner: all sources pending, then the mask goes to zero
        pvsr_host_i.wr(5'h1e, 16'h00fe);
        @(negedge clk_i) events_i <= 7'h7f;
        @(negedge clk_i) events_i <= '0;
        cmp(16'h1, 16'(irq_o), "irq_on");
        pvsr_host_i.wr(5'h1e, 16'h0);
        @(negedge clk_i);
        cmp(16'h0, 16'(irq_o), "irq_off");
        rd(5'h1d, 16'h00fe, "flags_all");
        stop_test();
    end
endmodule : test_pvsr_bank
bind pvsr_bank pvsr_bank_asserts pvsr_bank_asserts_i (.*);
